// >>> core/adcc_pkg.sv
// Purpose: constants for the channel-one config and incremental converter registers
// Assumes: 8-bit register port, byte addresses as printed
// Notes: status and mask offsets sit at 0x5e and 0x5f, past the printed block
package adcc_pkg;
  localparam int ADCC_ADDR_W = 8;
  localparam int ADCC_DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADCC_OFF_CH1_INPUT = 8'h50;
  localparam logic [7:0] ADCC_OFF_CONV_CTRL = 8'h51;
  localparam logic [7:0] ADCC_OFF_CH1_VOLUME = 8'h52;
  localparam logic [7:0] ADCC_OFF_IRQ_STATUS = 8'h5e;
  localparam logic [7:0] ADCC_OFF_IRQ_MASK = 8'h5f;

  // reset values
  localparam logic [7:0] ADCC_RST_CH1_INPUT = 8'h00;
  localparam logic [7:0] ADCC_RST_CONV_CTRL = 8'h00;
  localparam logic [7:0] ADCC_RST_CH1_VOLUME = 8'ha1;
  localparam logic [1:0] ADCC_RST_IRQ = 2'h0;

  // ch1_input_config fields
  localparam int ADCC_SRC_HI = 7;
  localparam int ADCC_SRC_LO = 6;
  localparam int ADCC_IMP_HI = 5;
  localparam int ADCC_IMP_LO = 4;
  localparam int ADCC_TOL_HI = 3;
  localparam int ADCC_TOL_LO = 2;
  localparam int ADCC_FS_BIT = 1;
  localparam int ADCC_BW_BIT = 0;

  // incremental_conv_control fields
  localparam int ADCC_EN_BIT = 7;
  localparam int ADCC_MODE_HI = 6;
  localparam int ADCC_MODE_LO = 5;
  localparam int ADCC_START_BIT = 4;
  localparam int ADCC_STOP_BIT = 3;
  localparam int ADCC_DONE_BIT = 2;

  // interrupt status bits
  localparam int ADCC_IRQ_DONE_BIT = 0;
  localparam int ADCC_IRQ_SEQ_BIT = 1;
  localparam int ADCC_IRQ_W = 2;

  // source codes
  localparam logic [1:0] ADCC_SRC_DIFF = 2'h0;
  localparam logic [1:0] ADCC_SRC_SE = 2'h1;
  localparam logic [1:0] ADCC_SRC_MUX_POS = 2'h2;
  localparam logic [1:0] ADCC_SRC_MUX_NEG = 2'h3;

  // impedance and tolerance codes
  localparam logic [1:0] ADCC_IMP_LOW = 2'h0;
  localparam logic [1:0] ADCC_IMP_MID = 2'h1;
  localparam logic [1:0] ADCC_IMP_HIGH = 2'h2;
  localparam logic [1:0] ADCC_TOL_SMALL = 2'h0;
  localparam logic [1:0] ADCC_TOL_MEDIUM = 2'h1;
  localparam logic [1:0] ADCC_TOL_RAIL = 2'h2;
  localparam logic [1:0] ADCC_CODE_RSVD = 2'h3;

  // volume
  localparam logic [7:0] ADCC_VOL_MUTE = 8'h00;
  localparam logic signed [8:0] ADCC_VOL_UNITY = 9'sh0a1;

  typedef enum logic [1:0] {
    ADCC_MODE_ONE_SINGLE = 2'h0,
    ADCC_MODE_ONE_MULTI = 2'h1,
    ADCC_MODE_SEQ_SINGLE = 2'h2,
    ADCC_MODE_SEQ_MULTI = 2'h3
  } adcc_mode_e;

  typedef enum logic [1:0] {
    ADCC_ST_IDLE = 2'h0,
    ADCC_ST_ONE_BUSY = 2'h1,
    ADCC_ST_SEQ_RUN = 2'h2
  } adcc_state_e;
endpackage : adcc_pkg

// >>> core/adcc_vol_map.sv
// Purpose: maps the volume code to mute and a signed half-dB gain
// Assumes: code 161 is unity, one code per half dB
// Notes: outputs registered, one cycle behind the code
`timescale 1ns/1ps
module adcc_vol_map (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [7:0] vol_code,
  output logic mute_q,
  output logic signed [8:0] gain_q
);
  import adcc_pkg::*;

  logic mute_d;
  logic signed [8:0] gain_d;

  assign mute_d = (vol_code == ADCC_VOL_MUTE);
  assign gain_d = $signed({1'b0, vol_code}) - ADCC_VOL_UNITY;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mute_q <= 1'b0;
      gain_q <= 9'sh000;
    end else if (en) begin
      mute_q <= mute_d;
      gain_q <= gain_d;
    end
  end

  AST_VOL_GAIN: assert property (@(posedge clk) disable iff (!nrst)
    en |=> gain_q == $signed({1'b0, $past(vol_code)}) - ADCC_VOL_UNITY)
    else $error("volume gain not code minus unity");
endmodule : adcc_vol_map

// >>> core/adcc_conv_ctrl.sv
// Purpose: one-shot and sequential sequencing of the incremental converter
// Assumes: converter acks a launch request and pulses done per conversion
// Notes: done flag set wins over its clear
`timescale 1ns/1ps
module adcc_conv_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic conv_enable,
  input wire adcc_pkg::adcc_mode_e conv_mode,
  input wire logic start_req,
  input wire logic stop_bit,
  input wire logic conv_ack,
  input wire logic conv_done,
  output logic conv_req_q,
  output logic seq_run_q,
  output logic done_flag_q,
  output logic ev_done,
  output logic ev_seq
);
  import adcc_pkg::*;

  adcc_state_e state_q;
  adcc_state_e state_d;
  logic one_shot_mode;
  logic start_take;
  logic accepted;
  logic finish_one;
  logic seq_go;
  logic seq_halt;
  logic conv_req_d;
  logic done_d;

  assign one_shot_mode = ~conv_mode[1];
  // a start outside an enabled one-shot mode has nothing to launch
  assign start_take = start_req & conv_enable & one_shot_mode;
  assign accepted = conv_req_q & conv_ack;
  assign finish_one = (state_q == ADCC_ST_ONE_BUSY) & conv_done;
  assign seq_go = conv_enable & ~one_shot_mode & ~stop_bit;
  assign seq_halt = ~seq_go;
  assign conv_req_d = conv_enable & (start_take | (conv_req_q & ~conv_ack));
  assign done_d = (done_flag_q & ~start_take) | (finish_one & conv_enable);
  assign ev_done = finish_one & conv_enable;
  assign ev_seq = (state_q == ADCC_ST_SEQ_RUN) & conv_done;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ADCC_ST_IDLE: begin
        if (accepted & conv_enable) begin
          state_d = ADCC_ST_ONE_BUSY;
        end else if (seq_go) begin
          state_d = ADCC_ST_SEQ_RUN;
        end
      end
      ADCC_ST_ONE_BUSY: begin
        if (conv_done | ~conv_enable) begin
          state_d = ADCC_ST_IDLE;
        end
      end
      ADCC_ST_SEQ_RUN: begin
        if (seq_halt) begin
          state_d = ADCC_ST_IDLE;
        end
      end
      default: begin
        state_d = ADCC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ADCC_ST_IDLE;
      conv_req_q <= 1'b0;
      seq_run_q <= 1'b0;
      done_flag_q <= 1'b0;
    end else if (en) begin
      state_q <= state_d;
      conv_req_q <= conv_req_d;
      seq_run_q <= (state_d == ADCC_ST_SEQ_RUN);
      done_flag_q <= done_d;
    end
  end

  sequence s_launch;
    en && start_take && !(finish_one && conv_enable);
  endsequence

  AST_START_CLEARS_DONE: assert property (@(posedge clk) disable iff (!nrst)
    s_launch |=> !done_flag_q && conv_req_q)
    else $error("start did not clear done and raise request");

  AST_ACK_DROPS_REQ: assert property (@(posedge clk) disable iff (!nrst)
    en && accepted && !start_take |=> !conv_req_q)
    else $error("request held after acceptance");

  AST_DONE_SETS: assert property (@(posedge clk) disable iff (!nrst)
    en && finish_one && conv_enable |=> done_flag_q ##1 (done_flag_q || $past(start_take)))
    else $error("done flag not set after one-shot end");

  AST_SEQ_STOP: assert property (@(posedge clk) disable iff (!nrst)
    en && seq_run_q && stop_bit |=> !seq_run_q)
    else $error("sequential run ignored stop");

  AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    en && !conv_enable |=> !conv_req_q && !seq_run_q)
    else $error("converter active while disabled");
endmodule : adcc_conv_ctrl

// >>> core/adcc_regs.sv
// Purpose: channel-one input, volume and incremental converter control registers
// Assumes: single clock, strobes synchronous, converter handshake synchronous
// Notes: read data valid only in the cycle after the read strobe
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Functional notes
// - source field bits 7-6: differential, single-ended, mux positive, mux negative.
// - impedance field bits 5-4: low, middle, high; code 3 reserved.
// - coupling field bits 3-2: small, medium, rail-to-rail tolerance; code 3 reserved.
// - full-scale bit 1: normal range when clear, doubled when set.
// - bandwidth bit 0: audio or wide; wide only with highest impedance.
// - mode bits 6-5 pick one-shot/sequential, single/multi; active only when bit 7 set.
// - single-channel modes take the channel from the source mux selection.
// - writing one to bit 4 launches one conversion; zero does nothing.
// - bit 3 clear lets sequential run continue; set halts it.
// - read-only done flag shows one once a one-shot conversion finished.
// - volume code 0 mutes; 1 most negative gain; 255 most positive.
// - half-dB volume steps, 161 is unity and the reset value.
module adcc_regs #(
  parameter int ADDR_W = adcc_pkg::ADCC_ADDR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic conv_ack,
  input wire logic conv_done,
  output logic [1:0] ch1_source_select,
  output logic [1:0] ch1_impedance_select,
  output logic [1:0] ch1_common_mode_tolerance,
  output logic ch1_full_scale_select,
  output logic ch1_bandwidth_select,
  output logic ch1_volume_mute,
  output logic signed [8:0] ch1_volume_gain,
  output logic incremental_conv_enable,
  output adcc_pkg::adcc_mode_e incremental_conv_mode,
  output logic conv_channel_neg,
  output logic conv_multi,
  output logic conv_req,
  output logic seq_run,
  output logic irq
);
  import adcc_pkg::*;

  generate
    if (ADDR_W < 7 || ADDR_W > ADCC_ADDR_W) begin : g_bad_addr
      $error("ADDR_W must hold offsets up to 0x5f and fit 8 bits");
    end
  endgenerate

  // stored register fields
  logic [1:0] src_q;
  logic [1:0] imp_q;
  logic [1:0] tol_q;
  logic fs_q;
  logic bw_q;
  logic conv_en_q;
  adcc_mode_e mode_q;
  logic stop_q;
  logic [7:0] vol_q;
  logic [ADCC_IRQ_W-1:0] status_q;
  logic [ADCC_IRQ_W-1:0] mask_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic bw_eff_q;
  logic chan_neg_q;
  logic multi_q;

  // next values
  logic [1:0] src_d;
  logic [1:0] imp_d;
  logic [1:0] tol_d;
  logic fs_d;
  logic bw_d;
  logic conv_en_d;
  adcc_mode_e mode_d;
  logic stop_d;
  logic [7:0] vol_d;
  logic [ADCC_IRQ_W-1:0] status_d;
  logic [ADCC_IRQ_W-1:0] mask_d;
  logic [7:0] rdata_d;
  logic bw_eff_d;
  logic chan_neg_d;
  logic multi_d;

  // address decode
  logic [7:0] addr8;
  logic wr_input;
  logic wr_ctrl;
  logic wr_vol;
  logic wr_stat;
  logic wr_mask;
  logic hit_input;
  logic hit_ctrl;
  logic hit_vol;
  logic hit_stat;
  logic hit_mask;

  // converter sequencer wires
  logic start_req;
  logic conv_req_w;
  logic seq_run_w;
  logic done_flag_w;
  logic ev_done_w;
  logic ev_seq_w;
  logic [ADCC_IRQ_W-1:0] events;
  logic [ADCC_IRQ_W-1:0] stat_clr;

  // readback images
  logic [7:0] img_input;
  logic [7:0] img_ctrl;
  logic [7:0] img_vol;
  logic [7:0] img_stat;
  logic [7:0] img_mask;

  assign addr8 = 8'(reg_addr);
  assign hit_input = (addr8 == ADCC_OFF_CH1_INPUT);
  assign hit_ctrl = (addr8 == ADCC_OFF_CONV_CTRL);
  assign hit_vol = (addr8 == ADCC_OFF_CH1_VOLUME);
  assign hit_stat = (addr8 == ADCC_OFF_IRQ_STATUS);
  assign hit_mask = (addr8 == ADCC_OFF_IRQ_MASK);
  assign wr_input = reg_wr & hit_input;
  assign wr_ctrl = reg_wr & hit_ctrl;
  assign wr_vol = reg_wr & hit_vol;
  assign wr_stat = reg_wr & hit_stat;
  assign wr_mask = reg_wr & hit_mask;

  // input register: fields hold until written
  assign src_d = wr_input ? reg_wdata[ADCC_SRC_HI:ADCC_SRC_LO] : src_q;
  // reserved codes are dropped so the analogue side never sees them
  assign imp_d = (wr_input && reg_wdata[ADCC_IMP_HI:ADCC_IMP_LO] != ADCC_CODE_RSVD) ?
    reg_wdata[ADCC_IMP_HI:ADCC_IMP_LO] : imp_q;
  assign tol_d = (wr_input && reg_wdata[ADCC_TOL_HI:ADCC_TOL_LO] != ADCC_CODE_RSVD) ?
    reg_wdata[ADCC_TOL_HI:ADCC_TOL_LO] : tol_q;
  // range legality is left to software, the bit passes as written
  assign fs_d = wr_input ? reg_wdata[ADCC_FS_BIT] : fs_q;
  assign bw_d = wr_input ? reg_wdata[ADCC_BW_BIT] : bw_q;

  // wide band reaches the converter only at the highest impedance
  assign bw_eff_d = bw_q & (imp_q == ADCC_IMP_HIGH);

  // control register; bits 1-0 are not stored
  assign conv_en_d = wr_ctrl ? reg_wdata[ADCC_EN_BIT] : conv_en_q;
  assign mode_d = wr_ctrl ? adcc_mode_e'(reg_wdata[ADCC_MODE_HI:ADCC_MODE_LO]) : mode_q;
  assign stop_d = wr_ctrl ? reg_wdata[ADCC_STOP_BIT] : stop_q;
  // start is taken with the new enable and mode of the same write
  assign start_req = wr_ctrl & reg_wdata[ADCC_START_BIT];

  // single-channel modes route the mux selection to the converter
  assign chan_neg_d = ~mode_q[0] & (src_q == ADCC_SRC_MUX_NEG);
  assign multi_d = mode_q[0];

  // volume register
  assign vol_d = wr_vol ? reg_wdata : vol_q;

  // sticky status, write one to clear, new events win
  assign events[ADCC_IRQ_DONE_BIT] = ev_done_w;
  assign events[ADCC_IRQ_SEQ_BIT] = ev_seq_w;
  assign stat_clr = wr_stat ? reg_wdata[ADCC_IRQ_W-1:0] : {ADCC_IRQ_W{1'b0}};
  assign status_d = (status_q & ~stat_clr) | events;
  assign mask_d = wr_mask ? reg_wdata[ADCC_IRQ_W-1:0] : mask_q;

  // readback
  assign img_input = {src_q, imp_q, tol_q, fs_q, bw_q};
  assign img_ctrl = {conv_en_q, mode_q, conv_req_w, stop_q, done_flag_w, 2'h0};
  assign img_vol = vol_q;
  assign img_stat = {{(8 - ADCC_IRQ_W){1'b0}}, status_q};
  assign img_mask = {{(8 - ADCC_IRQ_W){1'b0}}, mask_q};
  // unmapped offsets read zero
  assign rdata_d = !reg_rd ? 8'h00 :
    hit_input ? img_input :
    hit_ctrl ? img_ctrl :
    hit_vol ? img_vol :
    hit_stat ? img_stat :
    hit_mask ? img_mask : 8'h00;

  adcc_conv_ctrl u_conv (
    .clk(clk),
    .nrst(nrst),
    .en(en),
    .conv_enable(conv_en_d),
    .conv_mode(mode_d),
    .start_req(start_req),
    .stop_bit(stop_d),
    .conv_ack(conv_ack),
    .conv_done(conv_done),
    .conv_req_q(conv_req_w),
    .seq_run_q(seq_run_w),
    .done_flag_q(done_flag_w),
    .ev_done(ev_done_w),
    .ev_seq(ev_seq_w)
  );

  adcc_vol_map u_vol (
    .clk(clk),
    .nrst(nrst),
    .en(en),
    .vol_code(vol_q),
    .mute_q(ch1_volume_mute),
    .gain_q(ch1_volume_gain)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {src_q, imp_q, tol_q, fs_q, bw_q} <= ADCC_RST_CH1_INPUT;
      bw_eff_q <= 1'b0;
    end else if (en) begin
      src_q <= src_d;
      imp_q <= imp_d;
      tol_q <= tol_d;
      fs_q <= fs_d;
      bw_q <= bw_d;
      bw_eff_q <= bw_eff_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_en_q <= ADCC_RST_CONV_CTRL[ADCC_EN_BIT];
      mode_q <= adcc_mode_e'(ADCC_RST_CONV_CTRL[ADCC_MODE_HI:ADCC_MODE_LO]);
      stop_q <= ADCC_RST_CONV_CTRL[ADCC_STOP_BIT];
      chan_neg_q <= 1'b0;
      multi_q <= 1'b0;
    end else if (en) begin
      conv_en_q <= conv_en_d;
      mode_q <= mode_d;
      stop_q <= stop_d;
      chan_neg_q <= chan_neg_d;
      multi_q <= multi_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vol_q <= ADCC_RST_CH1_VOLUME;
      status_q <= ADCC_RST_IRQ;
      mask_q <= ADCC_RST_IRQ;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (en) begin
      vol_q <= vol_d;
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_q & mask_q);
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign ch1_source_select = src_q;
  assign ch1_impedance_select = imp_q;
  assign ch1_common_mode_tolerance = tol_q;
  assign ch1_full_scale_select = fs_q;
  assign ch1_bandwidth_select = bw_eff_q;
  assign incremental_conv_enable = conv_en_q;
  assign incremental_conv_mode = mode_q;
  assign conv_channel_neg = chan_neg_q;
  assign conv_multi = multi_q;
  assign conv_req = conv_req_w;
  assign seq_run = seq_run_w;
  assign irq = irq_q;

  sequence s_rd_vol;
    en && reg_rd && hit_vol;
  endsequence

  sequence s_rd_ctrl;
    en && reg_rd && hit_ctrl;
  endsequence

  AST_RD_VOL: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_vol |=> reg_rdata == $past(vol_q))
    else $error("volume readback wrong");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    s_rd_ctrl |=> reg_rdata[1:0] == 2'h0 && reg_rdata[ADCC_DONE_BIT] == $past(done_flag_w))
    else $error("control readback reserved or done bit wrong");

  AST_SRC_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    en && wr_input |=> ch1_source_select == $past(reg_wdata[ADCC_SRC_HI:ADCC_SRC_LO]))
    else $error("source field not written");

  AST_IMP_RSVD: assert property (@(posedge clk) disable iff (!nrst)
    en && wr_input && reg_wdata[ADCC_IMP_HI:ADCC_IMP_LO] == ADCC_CODE_RSVD
    |=> $stable(ch1_impedance_select))
    else $error("reserved impedance code stored");

  AST_TOL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    !(en && wr_input) |=> $stable(ch1_common_mode_tolerance))
    else $error("tolerance changed without write");

  AST_BW_GATE: assert property (@(posedge clk) disable iff (!nrst)
    en |=> ch1_bandwidth_select == ($past(bw_q) && $past(imp_q) == ADCC_IMP_HIGH))
    else $error("wide band without highest impedance");

  AST_MUTE: assert property (@(posedge clk) disable iff (!nrst)
    en && vol_q == ADCC_VOL_MUTE |=> ch1_volume_mute)
    else $error("code zero did not mute");

  AST_CHAN_SEL: assert property (@(posedge clk) disable iff (!nrst)
    en && !mode_q[0] |=> conv_channel_neg == ($past(src_q) == ADCC_SRC_MUX_NEG))
    else $error("single mode channel not from source mux");

  AST_IRQ: assert property (@(posedge clk) disable iff (!nrst)
    en && (status_q & mask_q) != '0 |=> irq)
    else $error("unmasked status without interrupt");
endmodule : adcc_regs

// >>> testbench/adcc_regs_tb_top.sv
// Purpose: self-checking bench for the channel-one config and converter control registers
// Assumes: en held high except in the freeze case; converter handshake driven by the bench
// Notes: ordinary register cases come from a row table, the awkward ones follow by hand
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module adcc_regs_tb_top;
  import adcc_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } adcc_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic conv_ack = 1'b0;
  logic conv_done = 1'b0;
  logic [1:0] ch1_source_select, ch1_impedance_select, ch1_common_mode_tolerance;
  logic ch1_full_scale_select, ch1_bandwidth_select, ch1_volume_mute;
  logic signed [8:0] ch1_volume_gain;
  logic signed [8:0] gain_exp;
  logic incremental_conv_enable, conv_channel_neg, conv_multi, conv_req, seq_run, irq;
  adcc_mode_e incremental_conv_mode;
  int err_total = 0;
  int tests_run = 0;
  // reserved codes 3 leave the previous field value, so rows depend on order
  adcc_row_s rows[18] = '{
    '{8'h50, 8'h40, 8'h40}, '{8'h50, 8'h80, 8'h80}, '{8'h50, 8'hc0, 8'hc0},
    '{8'h50, 8'h10, 8'h10}, '{8'h50, 8'h20, 8'h20}, '{8'h50, 8'h30, 8'h20},
    '{8'h50, 8'h04, 8'h04}, '{8'h50, 8'h08, 8'h08}, '{8'h50, 8'h0c, 8'h08},
    '{8'h50, 8'h0a, 8'h0a}, '{8'h50, 8'h01, 8'h01}, '{8'h50, 8'h21, 8'h21},
    '{8'h52, 8'h00, 8'h00}, '{8'h52, 8'h01, 8'h01}, '{8'h52, 8'hff, 8'hff},
    '{8'h52, 8'ha2, 8'ha2}, '{8'h51, 8'h08, 8'h08}, '{8'h60, 8'hff, 8'h00}
  };

  adcc_regs dut (
    .clk(clk), .nrst(nrst), .en(en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_ack(conv_ack),
    .conv_done(conv_done), .ch1_source_select(ch1_source_select),
    .ch1_impedance_select(ch1_impedance_select),
    .ch1_common_mode_tolerance(ch1_common_mode_tolerance),
    .ch1_full_scale_select(ch1_full_scale_select),
    .ch1_bandwidth_select(ch1_bandwidth_select), .ch1_volume_mute(ch1_volume_mute),
    .ch1_volume_gain(ch1_volume_gain), .incremental_conv_enable(incremental_conv_enable),
    .incremental_conv_mode(incremental_conv_mode), .conv_channel_neg(conv_channel_neg),
    .conv_multi(conv_multi), .conv_req(conv_req), .seq_run(seq_run), .irq(irq)
  );

  always #2.5 clk = ~clk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data is taken only in the cycle after the strobe edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rdchk

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic pulse_done;
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    settle();
  endtask : pulse_done

  // bounded wait, a miss counts as a mismatch
  task automatic wait_req;
    int n;
    n = 0;
    while (conv_req !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(conv_req, 1'b1)
  endtask : wait_req

  task automatic one_shot;
    @(posedge clk);
    conv_ack <= 1'b1;
    @(posedge clk);
    conv_ack <= 1'b0;
    settle();
    `CHK(conv_req, 1'b0)
  endtask : one_shot

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rdchk(ADCC_OFF_CH1_INPUT, 8'h00);
    rdchk(ADCC_OFF_CONV_CTRL, 8'h00);
    rdchk(ADCC_OFF_CH1_VOLUME, 8'ha1);
    `CHK(ch1_volume_gain, 9'sh000)
    for (int i = 0; i < 18; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].exp);
      if (rows[i].addr == 8'h50) begin
        `CHK({ch1_source_select, ch1_impedance_select}, rows[i].exp[7:4])
        `CHK({ch1_common_mode_tolerance, ch1_full_scale_select}, rows[i].exp[3:1])
        `CHK(ch1_bandwidth_select, rows[i].exp[0] & (rows[i].exp[5:4] == 2'h2))
      end
      if (rows[i].addr == 8'h52) begin
        gain_exp = $signed({1'b0, rows[i].exp}) - 9'sd161;
        `CHK(ch1_volume_mute, rows[i].exp == 8'h00)
        if (rows[i].exp != 8'h00) `CHK(ch1_volume_gain, gain_exp)
      end
    end
    // clock enable low must freeze the register
    @(posedge clk);
    en <= 1'b0;
    wr(ADCC_OFF_CH1_VOLUME, 8'h11);
    en <= 1'b1;
    rdchk(ADCC_OFF_CH1_VOLUME, 8'ha2);
    // start is ignored without enable, and writing zero launches nothing
    wr(ADCC_OFF_CONV_CTRL, 8'h10);
    settle();
    `CHK(conv_req, 1'b0)
    wr(ADCC_OFF_CONV_CTRL, 8'h80);
    settle();
    `CHK(conv_req, 1'b0)
    wr(ADCC_OFF_IRQ_MASK, 8'h01);
    rdchk(ADCC_OFF_IRQ_MASK, 8'h01);
    // one-shot: pending start reads back, done clear until finished
    wr(ADCC_OFF_CONV_CTRL, 8'h90);
    wait_req();
    rdchk(ADCC_OFF_CONV_CTRL, 8'h90);
    one_shot();
    rdchk(ADCC_OFF_CONV_CTRL, 8'h80);
    pulse_done();
    rdchk(ADCC_OFF_CONV_CTRL, 8'h84);
    rdchk(ADCC_OFF_IRQ_STATUS, 8'h01);
    `CHK(irq, 1'b1)
    // a new start clears the done flag
    wr(ADCC_OFF_CONV_CTRL, 8'h90);
    wait_req();
    rdchk(ADCC_OFF_CONV_CTRL, 8'h90);
    one_shot();
    // the converter must finish before sequential modes can start
    pulse_done();
    rdchk(ADCC_OFF_CONV_CTRL, 8'h84);
    wr(ADCC_OFF_IRQ_STATUS, 8'h01);
    settle();
    `CHK(irq, 1'b0)
    rdchk(ADCC_OFF_IRQ_STATUS, 8'h00);
    // every mode, source on the negative mux input
    wr(ADCC_OFF_CH1_INPUT, 8'hc0);
    for (int m = 0; m < 4; m++) begin
      wr(ADCC_OFF_CONV_CTRL, {1'b1, 2'(m), 5'h00});
      settle();
      `CHK(incremental_conv_mode, 2'(m))
      `CHK(incremental_conv_enable, 1'b1)
      `CHK(conv_multi, m[0])
      `CHK(conv_channel_neg, ~m[0])
      `CHK(seq_run, m[1])
      if (m[1]) pulse_done();
    end
    // sequential samples are masked until mask bit 1 is set
    rdchk(ADCC_OFF_IRQ_STATUS, 8'h02);
    `CHK(irq, 1'b0)
    wr(ADCC_OFF_IRQ_MASK, 8'h03);
    settle();
    `CHK(irq, 1'b1)
    wr(ADCC_OFF_CONV_CTRL, 8'he8);
    settle();
    `CHK(seq_run, 1'b0)
    wr(ADCC_OFF_IRQ_STATUS, 8'h02);
    settle();
    `CHK(irq, 1'b0)
    // source on the positive mux input in single sequential mode
    wr(ADCC_OFF_CH1_INPUT, 8'h80);
    wr(ADCC_OFF_CONV_CTRL, 8'hc0);
    settle();
    `CHK(conv_channel_neg, 1'b0)
    wr(ADCC_OFF_CONV_CTRL, 8'h40);
    settle();
    `CHK(seq_run, 1'b0)
    `CHK(incremental_conv_enable, 1'b0)
    // second reset with the converter disabled and the volume muted
    wr(ADCC_OFF_CH1_VOLUME, 8'h00);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdchk(ADCC_OFF_CH1_INPUT, 8'h00);
    rdchk(ADCC_OFF_CH1_VOLUME, 8'ha1);
    rdchk(ADCC_OFF_IRQ_MASK, 8'h00);
    `CHK(ch1_volume_mute, 1'b0)
    conclude();
  end
endmodule : adcc_regs_tb_top
